// ===== common/tp_diag_pkg.sv
// Constants, types and the behaviour summary for the transport and diagnostic block
// What this block does
// RULE_01: Payloads above 8 bytes go by transport protocol; others as one frame.
// RULE_02: Large message to address 255 is broadcast with the announce sequence.
// RULE_03: Directed large message opens a connection; target grants packets with CTS.
// RULE_04: Accept broadcast and directed large messages; hand over only when complete.
// RULE_05: At most one outgoing transport session at any moment.
// RULE_06: Pending large outgoing messages leave strictly first-in first-out.
// RULE_07: Track up to 35 incoming sessions, any mixture of both kinds.
// RULE_08: At the limit, ignore new announcements and refuse new connection requests.
// RULE_09: Keep an active and a previously-active table per remote unit, both readable.
// RULE_10: Both tables: one 16-bit header word, then a list of entries.
// RULE_11: Header lamps: protect 0-1, amber 2-3, red 4-5, malfunction 6-7.
// RULE_12: Header bits 8-14 hold entry count, bit 15 flags overflow.
// RULE_13: Non-zero update rate and timeout force the count field to 0xFF.
// RULE_14: Each entry is 4 bytes: SPN, FMI and occurrence count.
// RULE_15: Method 0: byte0 SPN16-18 and FMI, byte1 count, bytes2-3 SPN low.
// RULE_16: Received conversion-method flag goes into bit 7 of entry byte 1.
// RULE_17: Version 1: byte0 SPN0-2, byte2 SPN11-18, byte3 SPN3-10.
// RULE_18: Version 2: byte0 SPN0-2, byte2 SPN3-10, byte3 SPN11-18.
// RULE_19: Version 3: byte0 SPN16-18, bytes2-3 SPN low sixteen as method 0.
// RULE_20: Recovery off: after bus-off stay offline until power cycle.
// RULE_21: Recovery on: after bus-off reinitialise controller, then come back online.
// RULE_22: Non-zero update rate: timeout when the message misses that interval.
// RULE_23: Entry layout per remote unit is chosen by a configuration setting.
package tp_diag_pkg;
    localparam int          SF_MAX      = 8;
    localparam int          DT_BYTES    = 7;
    localparam logic [7:0]  GLOBAL_DA   = 8'h00FF;
    localparam int          RX_SESS_DEF = 35;
    localparam int          ENT_DEF     = 127;
    localparam int          HDR_CNT_LSB = 8;
    localparam int          HDR_OVF_BIT = 15;
    localparam logic [7:0]  TMO_MARK    = 8'h00FF;
    localparam int          CLK_HZ      = 125_000_000;
    localparam int          TICK_MS     = 1;
    localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        FK_SINGLE = 2'b00,
        FK_BAM    = 2'b01,
        FK_RTS    = 2'b10,
        FK_DT     = 2'b11
    } frm_kind_t;

    typedef enum logic [1:0] {
        ENC_M0 = 2'b00,
        ENC_V1 = 2'b01,
        ENC_V2 = 2'b10,
        ENC_V3 = 2'b11
    } enc_t;

    typedef struct packed {
        logic [7:0]  dest;
        logic [11:0] len;
    } tx_req_t;

    typedef struct packed {
        frm_kind_t   kind;
        logic [7:0]  dest;
        logic [7:0]  seq;
        logic [11:0] len;
    } frame_t;

    typedef struct packed {
        logic [18:0] spn;
        logic [4:0]  fmi;
        logic [6:0]  oc;
        logic        cm;
    } dtc_t;
endpackage : tp_diag_pkg

// ===== rtl/tp_diag.sv
// Transport session engine, incoming session tracker, diagnostic tables, bus-off control
`timescale 1ns/100ps
module tp_diag import tp_diag_pkg::*; #(
    parameter int RX_SESS_MAX = RX_SESS_DEF,
    parameter int MAX_ENT     = ENT_DEF,
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    input  wire tx_req_t          TXQ_DATA,
    input  wire logic             TXQ_VALID,
    output      logic             TXQ_READY,
    output      frame_t           FRM_DATA,
    output      logic             FRM_VALID,
    input  wire logic             FRM_READY,
    input  wire logic             CTS_IN,
    input  wire logic [7:0]       CTS_NUM,
    input  wire logic             EOMA_IN,
    input  wire logic             ABORT_IN,
    output      logic             TX_BUSY,
    input  wire logic             RX_OPEN,
    input  wire logic             RX_OPEN_RTS,
    input  wire logic             RX_CLOSE,
    input  wire logic             RX_DROP,
    output      logic             RX_CTS,
    output      logic             RX_DENY,
    output      logic             RX_MSG_DONE,
    output      logic [5:0]       RX_SESS,
    input  wire logic             DM_START,
    input  wire logic             DM_ENTRY,
    input  wire logic             DM_TBL,
    input  wire logic [7:0]       DM_LAMPS,
    input  wire dtc_t             DM_DTC,
    input  wire enc_t             ENC_SEL,
    input  wire logic [1:0][15:0] UPD_MS,
    output      logic [1:0][15:0] HDR,
    output      logic             ENT_WR,
    output      logic             ENT_TBL,
    output      logic [6:0]       ENT_IDX,
    output      logic [31:0]      ENT_DATA,
    input  wire logic             BUS_OFF,
    input  wire logic             RECOV_EN,
    input  wire logic             REINIT_DONE,
    output      logic             CAN_REINIT,
    output      logic             ONLINE
);
    if (RX_SESS_MAX < 1 || RX_SESS_MAX > 63) begin : g_chk_sess
        $error("RX_SESS_MAX out of range");
    end
    if (MAX_ENT < 1 || MAX_ENT > 127) begin : g_chk_ent
        $error("MAX_ENT out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus-off supervision
    typedef enum logic [1:0] {
        BO_ON     = 2'b00,
        BO_DEAD   = 2'b01,
        BO_REINIT = 2'b10
    } bo_t;
    bo_t  bo_r;
    logic boff_s1_r;
    logic boff_s2_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            boff_s1_r <= 1'b0;
            boff_s2_r <= 1'b0;
        end else begin
            boff_s1_r <= BUS_OFF;
            boff_s2_r <= boff_s1_r;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bo_r <= BO_ON;
        end else begin
            unique case (bo_r)
                BO_ON: begin
                    // RULE_20 RULE_21 leave on bus-off
                    if (boff_s2_r) begin
                        bo_r <= RECOV_EN ? BO_REINIT : BO_DEAD;
                    end
                end
                // Only a reset, our power cycle, leaves this state
                BO_DEAD: bo_r <= BO_DEAD;
                BO_REINIT: begin
                    // RULE_21 back online
                    if (REINIT_DONE && !boff_s2_r) begin
                        bo_r <= BO_ON;
                    end
                end
                default: bo_r <= BO_DEAD;
            endcase
        end
    end
    assign ONLINE     = (bo_r == BO_ON);
    assign CAN_REINIT = (bo_r == BO_REINIT);

    a_dead_stays: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_20
        bo_r == BO_DEAD |=> !ONLINE && !FRM_VALID)
        else $error("offline state left");
    a_reinit_path: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_21
        ONLINE && boff_s2_r && RECOV_EN |=> CAN_REINIT)
        else $error("no reinit after bus-off");

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry queue of all outgoing messages, single-frame ones included, a stalled engine backs up the source
    tx_req_t    q_mem_r [2];
    logic       q_wp_r;
    logic       q_rp_r;
    logic [1:0] q_cnt_r;
    logic       q_pop;
    logic       q_push;
    assign TXQ_READY = (q_cnt_r != 2'd2);
    assign q_push    = TXQ_VALID && TXQ_READY;

    // RULE_06 strict FIFO order
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            q_wp_r  <= 1'b0;
            q_rp_r  <= 1'b0;
            q_cnt_r <= 2'd0;
            q_mem_r <= '{default: '0};
        end else begin
            if (q_push) begin
                q_mem_r[q_wp_r] <= TXQ_DATA;
                q_wp_r          <= ~q_wp_r;
            end
            if (q_pop) begin
                q_rp_r <= ~q_rp_r;
            end
            q_cnt_r <= q_cnt_r + {1'b0, q_push} - {1'b0, q_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outgoing session engine, one session at a time
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DT   = 2'b01,
        TX_WCTS = 2'b10,
        TX_WEOM = 2'b11
    } tx_t;
    tx_t        tx_r;
    tx_req_t    cur_r;
    logic [7:0] tot_r;
    logic [7:0] seq_r;
    logic [7:0] grant_r;
    tx_req_t    head;
    logic       bam;
    logic [7:0] npkt;
    assign head = q_mem_r[q_rp_r];
    assign bam  = (cur_r.dest == GLOBAL_DA);
    assign npkt = 8'((head.len + 12'(DT_BYTES - 1)) / 12'(DT_BYTES));
    // RULE_05 no pop while a session runs
    assign q_pop   = (tx_r == TX_IDLE) && !FRM_VALID && q_cnt_r != 2'd0 && ONLINE;
    assign TX_BUSY = (tx_r != TX_IDLE);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_r      <= TX_IDLE;
            cur_r     <= '0;
            tot_r     <= 8'h0000;
            seq_r     <= 8'h0000;
            grant_r   <= 8'h0000;
            FRM_VALID <= 1'b0;
            FRM_DATA  <= '0;
        end else begin
            if ((FRM_VALID && FRM_READY) || !ONLINE) begin
                FRM_VALID <= 1'b0;
            end
            unique case (tx_r)
                TX_IDLE: begin
                    if (q_pop) begin
                        cur_r          <= head;
                        tot_r          <= npkt;
                        seq_r          <= 8'h0000;
                        FRM_VALID      <= 1'b1;
                        FRM_DATA.dest  <= head.dest;
                        FRM_DATA.len   <= head.len;
                        FRM_DATA.seq   <= 8'h0000;
                        // RULE_01 single frame or transport
                        if (head.len <= 12'(SF_MAX)) begin
                            FRM_DATA.kind <= FK_SINGLE;
                        // RULE_02 broadcast announce
                        end else if (head.dest == GLOBAL_DA) begin
                            FRM_DATA.kind <= FK_BAM;
                            grant_r       <= npkt;
                            tx_r          <= TX_DT;
                        // RULE_03 open connection
                        end else begin
                            FRM_DATA.kind <= FK_RTS;
                            tx_r          <= TX_WCTS;
                        end
                    end
                end
                TX_DT: begin
                    if (!ONLINE) begin
                        tx_r <= TX_IDLE;
                    end else if (!FRM_VALID) begin
                        FRM_VALID     <= 1'b1;
                        FRM_DATA.kind <= FK_DT;
                        FRM_DATA.seq  <= seq_r + 8'h0001;
                        seq_r         <= seq_r + 8'h0001;
                        grant_r       <= grant_r - 8'h0001;
                        if (seq_r + 8'h0001 == tot_r) begin
                            tx_r <= bam ? TX_IDLE : TX_WEOM;
                        // RULE_03 wait for next grant
                        end else if (grant_r == 8'h0001 && !bam) begin
                            tx_r <= TX_WCTS;
                        end
                    end
                end
                TX_WCTS: begin
                    if (ABORT_IN || !ONLINE) begin
                        tx_r <= TX_IDLE;
                    // A zero grant is a hold; keep waiting
                    end else if (CTS_IN && CTS_NUM != 8'h0000) begin
                        grant_r <= CTS_NUM;
                        tx_r    <= TX_DT;
                    end
                end
                TX_WEOM: begin
                    if (EOMA_IN || ABORT_IN || !ONLINE) begin
                        tx_r <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    a_single_len: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_01
        q_pop && head.len <= 12'(SF_MAX) |=> FRM_VALID && FRM_DATA.kind == FK_SINGLE)
        else $error("short message not single frame");
    a_bam_dest: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_02
        q_pop && head.len > 12'(SF_MAX) && head.dest == GLOBAL_DA
        |=> FRM_DATA.kind == FK_BAM ##1 tx_r == TX_DT)
        else $error("broadcast not announced");
    a_rts_wait: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_03
        tx_r == TX_WCTS && !CTS_IN |=> tx_r != TX_DT)
        else $error("data sent without grant");
    a_one_sess: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_05
        TX_BUSY |=> q_cnt_r >= $past(q_cnt_r))
        else $error("second outgoing session");

    ////////////////////////////////////////////////////////////////////////////
    // Incoming session tracker
    logic full;
    logic open_ok;
    assign full    = (RX_SESS == 6'(RX_SESS_MAX));
    assign open_ok = RX_OPEN && !full && ONLINE;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RX_SESS     <= 6'd0;
            RX_CTS      <= 1'b0;
            RX_DENY     <= 1'b0;
            RX_MSG_DONE <= 1'b0;
        end else begin
            // RULE_07 count concurrent sessions
            RX_SESS <= RX_SESS + {5'd0, open_ok}
                       - {5'd0, (RX_CLOSE || RX_DROP) && RX_SESS != 6'd0};
            RX_CTS  <= open_ok && RX_OPEN_RTS;
            // RULE_08 refuse at limit, announcements dropped silently
            RX_DENY <= RX_OPEN && RX_OPEN_RTS && full && ONLINE;
            // RULE_04 hand over only complete messages
            RX_MSG_DONE <= RX_CLOSE && RX_SESS != 6'd0;
        end
    end

    a_sess_limit: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_07
        RX_SESS <= 6'(RX_SESS_MAX))
        else $error("session count above limit");
    a_deny_full: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_08
        RX_OPEN && RX_OPEN_RTS && full && ONLINE |=> RX_DENY && !RX_CTS)
        else $error("request not refused at limit");

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick for update-rate supervision
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_r;
    logic                             tick_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else begin
            tick_r     <= (tick_cnt_r == '0);
            tick_cnt_r <= (tick_cnt_r == '0) ? ($bits(tick_cnt_r))'(TICK_CYCLES - 1)
                                             : tick_cnt_r - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Entry encoding, byte 0 in the low bits
    function automatic logic [31:0] pack_ent(dtc_t d, enc_t e);
        logic [7:0] b0;
        logic [7:0] b2;
        logic [7:0] b3;
        b0 = {d.fmi, d.spn[18:16]};
        b2 = d.spn[7:0];
        b3 = d.spn[15:8];
        // RULE_17 RULE_18 low SPN bits beside FMI
        if (e == ENC_V1 || e == ENC_V2) begin
            b0 = {d.fmi, d.spn[2:0]};
            b2 = (e == ENC_V1) ? d.spn[18:11] : d.spn[10:3];
            b3 = (e == ENC_V1) ? d.spn[10:3] : d.spn[18:11];
        end
        // RULE_14 RULE_15 RULE_16 RULE_19 four-byte entry
        return {b3, b2, d.cm, d.oc, b0};
    endfunction : pack_ent

    logic [1:0][6:0]  ent_cnt_r;
    logic [1:0]       ovf_r;
    logic [1:0][7:0]  lamp_r;
    logic [1:0][15:0] age_r;
    logic [1:0]       tmo_r;

    // RULE_23 layout from configuration
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ENT_WR   <= 1'b0;
            ENT_TBL  <= 1'b0;
            ENT_IDX  <= 7'd0;
            ENT_DATA <= 32'h0000_0000;
        end else begin
            ENT_WR <= 1'b0;
            if (DM_ENTRY && ent_cnt_r[DM_TBL] < 7'(MAX_ENT)) begin
                ENT_WR   <= 1'b1;
                ENT_TBL  <= DM_TBL;
                ENT_IDX  <= ent_cnt_r[DM_TBL];
                ENT_DATA <= pack_ent(DM_DTC, ENC_SEL);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active and previously-active tables, index 0 and 1
    for (genvar t = 0; t < 2; t++) begin : g_tbl
        logic hit_start;
        logic hit_ent;
        assign hit_start = DM_START && DM_TBL == 1'(t);
        assign hit_ent   = DM_ENTRY && DM_TBL == 1'(t);

        // RULE_09 RULE_12 count and overflow per table
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                ent_cnt_r[t] <= 7'd0;
                ovf_r[t]     <= 1'b0;
                lamp_r[t]    <= 8'h0000;
            end else if (hit_start) begin
                ent_cnt_r[t] <= 7'd0;
                ovf_r[t]     <= 1'b0;
                lamp_r[t]    <= DM_LAMPS;
            end else if (hit_ent) begin
                if (ent_cnt_r[t] < 7'(MAX_ENT)) begin
                    ent_cnt_r[t] <= ent_cnt_r[t] + 7'd1;
                end else begin
                    ovf_r[t] <= 1'b1;
                end
            end
        end

        // RULE_22 missed interval declares timeout
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                age_r[t] <= 16'h0000;
                tmo_r[t] <= 1'b0;
            end else if (hit_start) begin
                age_r[t] <= 16'h0000;
                tmo_r[t] <= 1'b0;
            end else if (tick_r && UPD_MS[t] != 16'h0000) begin
                age_r[t] <= (age_r[t] == 16'hFFFF) ? age_r[t] : age_r[t] + 16'h0001;
                if (age_r[t] + 16'h0001 >= UPD_MS[t]) begin
                    tmo_r[t] <= 1'b1;
                end
            end
        end

        // RULE_10 RULE_11 RULE_13 header word
        assign HDR[t] = (tmo_r[t] && UPD_MS[t] != 16'h0000) ? {TMO_MARK, lamp_r[t]}
                                                          : {ovf_r[t], ent_cnt_r[t], lamp_r[t]};

        a_hdr_tmo: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_13
            tick_r && UPD_MS[t] == 16'h0001 && !hit_start
            |=> HDR[t][HDR_OVF_BIT:HDR_CNT_LSB] == TMO_MARK || UPD_MS[t] == 16'h0000)
            else $error("timeout not shown in header");
    end

    a_ent_layout: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_15
        DM_ENTRY && ENC_SEL == ENC_M0 && ent_cnt_r[DM_TBL] < 7'(MAX_ENT)
        |=> ENT_WR && ENT_DATA[31:16] == $past(DM_DTC.spn[15:0])
            && ENT_DATA[15] == $past(DM_DTC.cm))
        else $error("method 0 entry layout wrong");
endmodule : tp_diag

// ===== tb/ecu_model.sv
// Far-side unit model: takes frames with stalls, grants directed transfers, acks completion
`timescale 1ns/100ps
module ecu_model import tp_diag_pkg::*; (
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire frame_t     FRM_DATA,
    input  wire logic       FRM_VALID,
    output      logic       FRM_READY,
    output      logic       CTS_IN,
    output      logic [7:0] CTS_NUM,
    output      logic       EOMA_IN
);
    int   left_r;
    int   grant_r;
    int   wait_r;
    logic stall_r;
    // Every other cycle stalled, so the sender must hold its frame
    assign FRM_READY = ~stall_r;
    ////////////////////////////////////////////////////////////////////////////////
    // grants of up to two packets
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            stall_r <= 1'b0;
            left_r  <= 0;
            grant_r <= 0;
            wait_r  <= 0;
            CTS_IN  <= 1'b0;
            CTS_NUM <= 8'h00;
            EOMA_IN <= 1'b0;
        end else begin
            stall_r <= ~stall_r;
            CTS_IN  <= 1'b0;
            EOMA_IN <= 1'b0;
            // Count is only meaningful with the grant pulse
            CTS_NUM <= ~CTS_NUM;
            if (wait_r > 0) begin
                wait_r <= wait_r - 1;
            end
            if (wait_r == 1 && left_r == 0) begin
                EOMA_IN <= 1'b1;
            end else if (wait_r == 1) begin
                CTS_IN  <= 1'b1;
                CTS_NUM <= (left_r > 2) ? 8'h02 : 8'(left_r);
                grant_r <= (left_r > 2) ? 2 : left_r;
            end
            if (FRM_VALID && FRM_READY && FRM_DATA.kind == FK_RTS) begin
                left_r <= (int'(FRM_DATA.len) + 6) / 7;
                wait_r <= 3;
            end else if (FRM_VALID && FRM_READY && FRM_DATA.kind == FK_DT && left_r > 0) begin
                left_r  <= left_r - 1;
                grant_r <= grant_r - 1;
                if (grant_r == 1) begin
                    wait_r <= 3;
                end
            end
        end
    end
endmodule : ecu_model

// ===== tb/testbench.sv
// Self-checking bench for the transport and diagnostic block
`timescale 1ns/100ps
module testbench import tp_diag_pkg::*;;
    logic clk, reset_n, txq_valid, txq_ready, frm_valid, frm_ready, cts_in, eoma_in;
    logic rx_open, rx_open_rts, rx_close, rx_drop, rx_cts, rx_deny, rx_msg_done;
    logic dm_start, dm_entry, dm_tbl, ent_wr, ent_tbl, bus_off, recov_en, reinit_done;
    logic can_reinit, online, tx_busy;
    logic [7:0]       cts_num, dm_lamps, gi;
    logic [5:0]       rx_sess;
    logic [6:0]       ent_idx;
    logic [31:0]      ent_data, got;
    logic [1:0][15:0] upd_ms, hdr;
    tx_req_t          txq_data;
    frame_t           frm_data;
    frame_t           fq[$];
    dtc_t             dtc;
    enc_t             enc_sel;
    int               fails, num_checks, n;
    logic [29:0]      ef[9] = '{30'h0050_0008, 30'h2050_000F, 30'h3050_100F, 30'h3050_200F,
                                30'h3050_300F, 30'h1FF0_000E, 30'h3FF0_100E, 30'h3FF0_200E,
                                30'h0FF0_0003};

    tp_diag #(.MAX_ENT(4), .TICK_CYCLES(10)) uut (
        .CLK(clk), .RESET_N(reset_n), .TXQ_DATA(txq_data), .TXQ_VALID(txq_valid),
        .TXQ_READY(txq_ready), .FRM_DATA(frm_data), .FRM_VALID(frm_valid),
        .FRM_READY(frm_ready), .CTS_IN(cts_in), .CTS_NUM(cts_num), .EOMA_IN(eoma_in),
        .ABORT_IN(1'b0), .TX_BUSY(tx_busy), .RX_OPEN(rx_open), .RX_OPEN_RTS(rx_open_rts),
        .RX_CLOSE(rx_close), .RX_DROP(rx_drop), .RX_CTS(rx_cts), .RX_DENY(rx_deny),
        .RX_MSG_DONE(rx_msg_done), .RX_SESS(rx_sess), .DM_START(dm_start),
        .DM_ENTRY(dm_entry), .DM_TBL(dm_tbl), .DM_LAMPS(dm_lamps), .DM_DTC(dtc),
        .ENC_SEL(enc_sel), .UPD_MS(upd_ms), .HDR(hdr), .ENT_WR(ent_wr), .ENT_TBL(ent_tbl),
        .ENT_IDX(ent_idx), .ENT_DATA(ent_data), .BUS_OFF(bus_off), .RECOV_EN(recov_en),
        .REINIT_DONE(reinit_done), .CAN_REINIT(can_reinit), .ONLINE(online));
    ecu_model peer (.CLK(clk), .RESET_N(reset_n), .FRM_DATA(frm_data), .FRM_VALID(frm_valid),
        .FRM_READY(frm_ready), .CTS_IN(cts_in), .CTS_NUM(cts_num), .EOMA_IN(eoma_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [39:0] g, input logic [39:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk_val
    task automatic complete_run;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // Two cycles of watching, so either answer latency is caught
    task automatic open_sess(input logic rts, input logic ec, input logic ed);
        logic sc, sd;
        sc = 1'b0;
        sd = 1'b0;
        rx_open <= 1'b1;
        rx_open_rts <= rts;
        @(posedge clk);
        rx_open <= 1'b0;
        repeat (2) begin
            @(posedge clk);
            sc |= rx_cts;
            sd |= rx_deny;
        end
        chk_val({sc, sd}, {ec, ed}, "open answer");
    endtask : open_sess
    task automatic dm_begin(input logic t, input logic [7:0] l);
        dm_tbl <= t;
        dm_lamps <= l;
        dm_start <= 1'b1;
        @(posedge clk);
        dm_start <= 1'b0;
        @(posedge clk);
    endtask : dm_begin
    task automatic dm_put(input dtc_t d);
        {gi, got} = 'x;
        dtc <= d;
        dm_entry <= 1'b1;
        @(posedge clk);
        dm_entry <= 1'b0;
        repeat (4) begin
            @(posedge clk);
            if (ent_wr === 1'b1) {gi, got} = {ent_tbl, ent_idx, ent_data};
        end
    endtask : dm_put
    function automatic logic [31:0] exp_ent(input enc_t e, input dtc_t d);
        logic [7:0] b2, b3;
        b2 = (e == ENC_V1) ? d.spn[18:11] : (e == ENC_V2) ? d.spn[10:3] : d.spn[7:0];
        b3 = (e == ENC_V1) ? d.spn[10:3] : (e == ENC_V2) ? d.spn[18:11] : d.spn[15:8];
        return {b3, b2, d.cm, d.oc, d.fmi, (e == ENC_V1 || e == ENC_V2) ? d.spn[2:0]
                : d.spn[18:16]};
    endfunction : exp_ent
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (frm_valid && frm_ready) fq.push_back(frm_data);
    end
    initial begin
        #(8 * 5000);
        fails++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        {reset_n, txq_valid, rx_open, rx_open_rts, rx_close, rx_drop} = '0;
        {dm_start, dm_entry, dm_tbl, bus_off, recov_en, reinit_done} = '0;
        {txq_data, dm_lamps, dtc, upd_ms} = '0;
        enc_sel = ENC_M0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // Single, directed, broadcast, short broadcast: queued back to back
        for (int i = 0; i < 4; i++) begin
            txq_data <= (i == 0) ? {8'h05, 12'h008} : (i == 1) ? {8'h05, 12'h00F}
                      : (i == 2) ? {8'hFF, 12'h00E} : {8'hFF, 12'h003};
            txq_valid <= 1'b1;
            n = 0;
            @(posedge clk);
            while (!txq_ready && n < 200) begin
                @(posedge clk);
                n++;
            end
        end
        txq_valid <= 1'b0;
        n = 0;
        while (fq.size() < 9 && n < 500) begin
            @(posedge clk);
            n++;
        end
        chk_val({tx_busy, fq.size()}, {1'b0, 32'd9}, "frame count");
        for (int i = 0; i < 9 && i < fq.size(); i++) begin
            chk_val(fq[i], ef[i], "frame order");
        end
        for (int i = 0; i < 35; i++) begin
            open_sess(i[0], i[0], 1'b0);
        end
        chk_val(rx_sess, 35, "sessions full");
        open_sess(1'b1, 1'b0, 1'b1);
        open_sess(1'b0, 1'b0, 1'b0);
        chk_val(rx_sess, 35, "sessions held");
        rx_close <= 1'b1;
        @(posedge clk);
        rx_close <= 1'b0;
        @(posedge clk);
        chk_val({rx_msg_done, rx_sess}, {1'b1, 6'd34}, "message handed on");
        rx_drop <= 1'b1;
        @(posedge clk);
        rx_drop <= 1'b0;
        repeat (2) @(posedge clk);
        chk_val(rx_sess, 33, "session dropped");
        for (int i = 0; i < 4; i++) begin
            enc_sel <= enc_t'(i);
            dm_begin(1'b0, 8'hE4);
            dm_put('{19'h5_A3C7 ^ 19'(i * 97), 5'h13, 7'h2A, i[0]});
            chk_val(got, exp_ent(enc_t'(i), dtc), "entry layout");
            chk_val({gi, hdr[0]}, {9'd0, 7'd1, 8'hE4}, "header");
        end
        dm_begin(1'b1, 8'h1B);
        for (int i = 0; i < 5; i++) dm_put('{19'h7_0001 + 19'(i), 5'h02, 7'h01, 1'b0});
        chk_val(hdr[1], {1'b1, 7'd4, 8'h1B}, "overflow");
        upd_ms <= {16'h0001, 16'h0000};
        repeat (30) @(posedge clk);
        chk_val(hdr[1], {8'hFF, 8'h1B}, "timeout");
        dm_begin(1'b1, 8'h1B);
        chk_val(hdr[1], {8'h00, 8'h1B}, "timeout cleared");
        upd_ms <= '0;
        recov_en <= 1'b1;
        bus_off <= 1'b1;
        n = 0;
        while (can_reinit !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk_val({can_reinit, online}, 2'b10, "reinit");
        bus_off <= 1'b0;
        reinit_done <= 1'b1;
        n = 0;
        while (online !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk_val({can_reinit, online}, 2'b01, "back online");
        {reinit_done, recov_en} <= 2'b00;
        bus_off <= 1'b1;
        repeat (10) @(posedge clk);
        bus_off <= 1'b0;
        reinit_done <= 1'b1;
        repeat (20) @(posedge clk);
        chk_val({can_reinit, online}, 2'b00, "stays offline");
        open_sess(1'b1, 1'b0, 1'b0);
        chk_val(rx_sess, 33, "offline ignores");
        complete_run();
    end
endmodule : testbench
